// ### hw/exti_route.sv
// External-interrupt port routing: pin edge/level detection, nibble routing
// to per-bit or per-port pending flags, Avalon-MM register slave.
// Assumes pins are asynchronous; CPU mask bits come from the same clock.
`default_nettype none

// Function
// - Bit 7 of select A picks E or F.
// - Bit 6 A routes F[3:0] to port line.
// - Bit 5 A routes E[7:4] to port line.
// - Bit 4 A routes E[3:0] to port line.
// - Bit 3 A routes D[7:4] to port line.
// - Bit 2 A routes D[3:0] to port line.
// - Bit 1 A routes B[7:4] to port line.
// - Bit 0 A routes B[3:0] to port line.
// - Select A at index 5, resets zero.
// - Select B at index 0xB, bit 7 reserved.
// - Bit 6 of select B picks D or H.
// - Bit 5 of select B picks B or G.
// - Bit 4 B routes H[7:4] to port line.
// - Bit 3 B routes H[3:0] to port line.
// - Bit 2 B routes G[7:4] to port line.
// - Bit 1 B routes G[3:0] to port line.
// - Bit 0 B routes F[7:4] to port line.
// - Sensitivity codes: low, rise, fall, both.
// - Sensitivity writable only when both masks set.
// - Flags set by events, cleared writing one.
module exti_route
	import exti_route_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	// Avalon-MM slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Processor interrupt mask
	input  wire logic        i_cpu_mask_high,
	input  wire logic        i_cpu_mask_low,
	// Port pins
	input  wire logic [7:0]  i_portb_pins,
	input  wire logic [7:0]  i_portd_pins,
	input  wire logic [7:0]  i_porte_pins,
	input  wire logic [7:0]  i_portf_pins,
	input  wire logic [7:0]  i_portg_pins,
	input  wire logic [7:0]  i_porth_pins,
	// Pending lines
	output logic      [3:0]  o_per_bit_lines_low,
	output logic      [3:0]  o_per_bit_lines_high,
	output logic             o_portb_dedicated_irq,
	output logic             o_portd_dedicated_irq,
	output logic             o_porte_dedicated_irq,
	output logic             o_portf_dedicated_irq,
	output logic             o_portg_dedicated_irq,
	output logic             o_porth_dedicated_irq
);
	import exti_route_pkg::*;

	localparam int NPINS = NUM_PORTS * 8;

	// Registers
	logic [7:0]       bit03_sens_r;
	logic [7:0]       bit47_sens_r;
	logic [7:0]       port_sens_r;
	logic [7:0]       port_gh_sens_r;
	logic [7:0]       bit_pend_r;
	logic [7:0]       bit_pend_nxt;
	logic [7:0]       port_pend_r;
	logic [7:0]       port_pend_nxt;
	logic [7:0]       route_sel_a_r;
	logic [7:0]       route_sel_b_r;
	logic             ack_r;
	logic [31:0]      rdata_r;

	// Pin synchronisers
	logic [NPINS-1:0] sync1_r;
	logic [NPINS-1:0] sync2_r;
	logic [NPINS-1:0] sync3_r;
	logic [NPINS-1:0] pin_r;
	logic [NPINS-1:0] pin_prev_r;

	// Decode
	wire logic [NPINS-1:0] pins_w = {i_porth_pins, i_portg_pins, i_portf_pins,
		i_porte_pins, i_portd_pins, i_portb_pins};
	wire logic       req_w      = i_avs_read | i_avs_write;
	wire logic       wr_w       = i_avs_write & ack_r & i_avs_byteenable[0];
	wire logic [7:0] wbyte_w    = i_avs_writedata[7:0];
	wire logic       sens_ok_w  = i_cpu_mask_high & i_cpu_mask_low;
	wire logic       wr_b03_w   = wr_w & (i_avs_address == IDX_BIT0_3_SENS) & sens_ok_w;
	wire logic       wr_b47_w   = wr_w & (i_avs_address == IDX_BIT4_7_SENS) & sens_ok_w;
	wire logic       wr_ps_w    = wr_w & (i_avs_address == IDX_PORT_SENS) & sens_ok_w;
	wire logic       wr_gh_w    = wr_w & (i_avs_address == IDX_PORT_GH_SENS) & sens_ok_w;
	wire logic       wr_bp_w    = wr_w & (i_avs_address == IDX_BIT_PENDING);
	wire logic       wr_pp_w    = wr_w & (i_avs_address == IDX_PORT_PENDING);
	wire logic       wr_sa_w    = wr_w & (i_avs_address == IDX_ROUTE_SEL_A);
	wire logic       wr_sb_w    = wr_w & (i_avs_address == IDX_ROUTE_SEL_B);

	// Nibble routes, slot n = port * 2 + high half
	wire logic [11:0] route_w = {
		route_sel_b_r[POS_PORTH_HIGH_NIBBLE_ROUTE],
		route_sel_b_r[POS_PORTH_LOW_NIBBLE_ROUTE],
		route_sel_b_r[POS_PORTG_HIGH_NIBBLE_ROUTE],
		route_sel_b_r[POS_PORTG_LOW_NIBBLE_ROUTE],
		route_sel_b_r[POS_PORTF_HIGH_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTF_LOW_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTE_HIGH_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTE_LOW_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTD_HIGH_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTD_LOW_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTB_HIGH_NIBBLE_ROUTE],
		route_sel_a_r[POS_PORTB_LOW_NIBBLE_ROUTE]};

	// Shared selectors: which port of each pair may raise its flag
	wire logic sel_ef_w = route_sel_a_r[POS_SHARED_EF_SOURCE_SEL];
	wire logic sel_dh_w = route_sel_b_r[POS_SHARED_DH_SOURCE_SEL];
	wire logic sel_bg_w = route_sel_b_r[POS_SHARED_BG_SOURCE_SEL];
	wire logic [NUM_PORTS-1:0] active_w = {sel_dh_w, sel_bg_w, sel_ef_w,
		~sel_ef_w, ~sel_dh_w, ~sel_bg_w};

	wire logic [15:0] bit_sens_w  = {bit47_sens_r, bit03_sens_r};
	wire logic [11:0] port_sens_w = {port_gh_sens_r[3:0], port_sens_r};

	function automatic logic pin_event(input logic [1:0] sens, input logic cur,
			input logic prv);
		logic ev;
		ev = 1'b0;
		unique case (sens)
			SENS_FALL_LOW: ev = ~cur;
			SENS_RISE:     ev = cur & ~prv;
			SENS_FALL:     ev = ~cur & prv;
			SENS_BOTH:     ev = cur ^ prv;
		endcase
		return ev;
	endfunction : pin_event

	logic [NPINS-1:0]     pin_bit_ev;
	logic [NPINS-1:0]     pin_port_ev;
	logic [7:0]           bit_ev;
	logic [NUM_PORTS-1:0] port_ev;

	// Per-pin detection and routing
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			localparam int P = gi / 8;
			localparam int X = gi % 8;
			localparam int N = gi / 4;
			assign pin_bit_ev[gi]  = ~route_w[N] &
				pin_event(bit_sens_w[2*X +: 2], pin_r[gi], pin_prev_r[gi]);
			assign pin_port_ev[gi] = route_w[N] & active_w[P] &
				pin_event(port_sens_w[2*P +: 2], pin_r[gi], pin_prev_r[gi]);
		end
		for (gi = 0; gi < 8; gi++) begin : g_bitline
			assign bit_ev[gi] = pin_bit_ev[gi] | pin_bit_ev[8+gi] | pin_bit_ev[16+gi] |
				pin_bit_ev[24+gi] | pin_bit_ev[32+gi] | pin_bit_ev[40+gi];
		end
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_portline
			assign port_ev[gi] = |pin_port_ev[8*gi +: 8];
		end
	endgenerate

	// Set wins over a same-cycle clear
	assign bit_pend_nxt  = (bit_pend_r & ~(wr_bp_w ? wbyte_w : 8'h00)) | bit_ev;
	assign port_pend_nxt = ((port_pend_r & ~(wr_pp_w ? wbyte_w : 8'h00)) |
		{2'h0, port_ev}) & MASK_PORT_PENDING;

	// Read mux
	logic [7:0] rbyte_w;
	always_comb begin
		unique case (i_avs_address)
			IDX_BIT0_3_SENS:  rbyte_w = bit03_sens_r;
			IDX_BIT4_7_SENS:  rbyte_w = bit47_sens_r;
			IDX_PORT_SENS:    rbyte_w = port_sens_r;
			IDX_BIT_PENDING:  rbyte_w = bit_pend_r;
			IDX_PORT_PENDING: rbyte_w = port_pend_r;
			IDX_ROUTE_SEL_A:  rbyte_w = route_sel_a_r;
			IDX_PORT_GH_SENS: rbyte_w = port_gh_sens_r;
			IDX_ROUTE_SEL_B:  rbyte_w = route_sel_b_r;
			default:          rbyte_w = 8'h00;
		endcase
	end

	// Bus handshake: one wait cycle per request
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req_w & ~ack_r;
			if (i_avs_read & ~ack_r)
				rdata_r <= {24'h00_0000, rbyte_w};
		end
	end

	assign o_avs_waitrequest = req_w & ~ack_r;
	assign o_avs_readdata    = rdata_r;

	// Pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			sync1_r    <= '0;
			sync2_r    <= '0;
			sync3_r    <= '0;
			pin_r      <= '0;
			pin_prev_r <= '0;
		end else begin
			sync1_r    <= pins_w;
			sync2_r    <= sync1_r;
			sync3_r    <= sync2_r;
			pin_r      <= (sync2_r & sync3_r) | (pin_r & (sync2_r ^ sync3_r));
			pin_prev_r <= pin_r;
		end
	end

	// Sensitivity and routing registers
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			bit03_sens_r   <= RST_SENS;
			bit47_sens_r   <= RST_SENS;
			port_sens_r    <= RST_SENS;
			port_gh_sens_r <= RST_SENS;
			route_sel_a_r  <= RST_ROUTE_SEL;
			route_sel_b_r  <= RST_ROUTE_SEL;
		end else begin
			if (wr_b03_w) bit03_sens_r <= wbyte_w;
			if (wr_b47_w) bit47_sens_r <= wbyte_w;
			if (wr_ps_w) port_sens_r <= wbyte_w;
			if (wr_gh_w) port_gh_sens_r <= wbyte_w & MASK_PORT_GH_SENS;
			if (wr_sa_w) route_sel_a_r <= wbyte_w;
			if (wr_sb_w) route_sel_b_r <= wbyte_w & MASK_ROUTE_SEL_B;
		end
	end

	// Pending flags
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			bit_pend_r  <= RST_PENDING;
			port_pend_r <= RST_PENDING;
		end else begin
			bit_pend_r  <= bit_pend_nxt;
			port_pend_r <= port_pend_nxt;
		end
	end

	assign o_per_bit_lines_low   = bit_pend_r[3:0];
	assign o_per_bit_lines_high  = bit_pend_r[7:4];
	assign o_portb_dedicated_irq = port_pend_r[PORT_B];
	assign o_portd_dedicated_irq = port_pend_r[PORT_D];
	assign o_porte_dedicated_irq = port_pend_r[PORT_E];
	assign o_portf_dedicated_irq = port_pend_r[PORT_F];
	assign o_portg_dedicated_irq = port_pend_r[PORT_G];
	assign o_porth_dedicated_irq = port_pend_r[PORT_H];

	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	wire logic lo_all_routed_w = route_w[0] & route_w[2] & route_w[4] & route_w[6] &
		route_w[8] & route_w[10];

	property p_ef_pick_f;
		$rose(port_pend_r[PORT_F]) |-> $past(sel_ef_w) && $past(route_w[6] | route_w[7]);
	endproperty
	a_ef_pick_f: assert property (p_ef_pick_f) else $error("F flag rose while E picked");

	property p_ef_pick_e;
		$rose(port_pend_r[PORT_E]) |-> !$past(sel_ef_w) && $past(route_w[4] | route_w[5]);
	endproperty
	a_ef_pick_e: assert property (p_ef_pick_e) else $error("E flag rose while F picked");

	property p_dh_pick;
		$rose(port_pend_r[PORT_H]) |-> $past(sel_dh_w) && $past(route_w[10] | route_w[11]);
	endproperty
	a_dh_pick: assert property (p_dh_pick) else $error("H flag rose without selection");

	property p_bg_pick;
		$rose(port_pend_r[PORT_B]) |-> !$past(sel_bg_w) && $past(route_w[0] | route_w[1]);
	endproperty
	a_bg_pick: assert property (p_bg_pick) else $error("B flag rose without selection");

	property p_nibble_excl;
		$past(lo_all_routed_w) && $past(wr_bp_w) == 1'b0 |->
			(bit_pend_r[3:0] & ~$past(bit_pend_r[3:0])) == 4'h0;
	endproperty
	a_nibble_excl: assert property (p_nibble_excl) else $error("Routed nibble set bit flag");

	property p_reset_zero;
		$past(i_reset) |-> route_sel_a_r == RST_ROUTE_SEL && route_sel_b_r == RST_ROUTE_SEL;
	endproperty
	a_reset_zero: assert property (disable iff (1'b0) p_reset_zero)
		else $error("Select not zero after reset");

	property p_reserved;
		route_sel_b_r[7] == 1'b0 && port_pend_r[7:6] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved bit set");

	property p_sens_lock;
		$past(wr_w && !sens_ok_w) |-> $stable(bit03_sens_r) && $stable(port_sens_r);
	endproperty
	a_sens_lock: assert property (p_sens_lock) else $error("Sensitivity changed while locked");

	property p_set_wins;
		$past(bit_ev[0] && !i_reset) |-> bit_pend_r[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Bit event lost");

	property p_w1c;
		$past(wr_bp_w && wbyte_w[1] && !bit_ev[1]) |-> !bit_pend_r[1];
	endproperty
	a_w1c: assert property (p_w1c) else $error("Write one did not clear flag");

	property p_rise_only;
		port_sens_r[1:0] == SENS_RISE && route_w[0] && !sel_bg_w && $rose(pin_r[0])
			|=> port_pend_r[PORT_B];
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("Rising edge missed");

	sequence s_req_wait;
		req_w && o_avs_waitrequest;
	endsequence
	sequence s_req_done;
		!o_avs_waitrequest;
	endsequence
	property p_bus_answer;
		s_req_wait |=> s_req_done;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("Bus answer late");

endmodule : exti_route

`default_nettype wire

// ### hw/exti_route_pkg.sv
// Package for the external-interrupt port routing block: register indices,
// field positions and reset values.
// Assumes an Avalon-MM slave with word addressing; byte address = 4 * index.
`default_nettype none

package exti_route_pkg;

	// Register indices (byte address is four times the index)
	localparam logic [3:0] IDX_BIT0_3_SENS    = 4'h0;
	localparam logic [3:0] IDX_BIT4_7_SENS    = 4'h1;
	localparam logic [3:0] IDX_PORT_SENS      = 4'h2;
	localparam logic [3:0] IDX_BIT_PENDING    = 4'h3;
	localparam logic [3:0] IDX_PORT_PENDING   = 4'h4;
	localparam logic [3:0] IDX_ROUTE_SEL_A    = 4'h5;
	localparam logic [3:0] IDX_PORT_GH_SENS   = 4'ha;
	localparam logic [3:0] IDX_ROUTE_SEL_B    = 4'hb;

	// Reset values
	localparam logic [7:0] RST_SENS           = 8'h00;
	localparam logic [7:0] RST_PENDING        = 8'h00;
	localparam logic [7:0] RST_ROUTE_SEL      = 8'h00;

	// Implemented bits; the rest read as zero
	localparam logic [7:0] MASK_PORT_GH_SENS  = 8'h0f;
	localparam logic [7:0] MASK_PORT_PENDING  = 8'h3f;
	localparam logic [7:0] MASK_ROUTE_SEL_B   = 8'h7f;

	// Fields of route select A
	localparam int POS_SHARED_EF_SOURCE_SEL   = 7;
	localparam int POS_PORTF_LOW_NIBBLE_ROUTE = 6;
	localparam int POS_PORTE_HIGH_NIBBLE_ROUTE = 5;
	localparam int POS_PORTE_LOW_NIBBLE_ROUTE = 4;
	localparam int POS_PORTD_HIGH_NIBBLE_ROUTE = 3;
	localparam int POS_PORTD_LOW_NIBBLE_ROUTE = 2;
	localparam int POS_PORTB_HIGH_NIBBLE_ROUTE = 1;
	localparam int POS_PORTB_LOW_NIBBLE_ROUTE = 0;

	// Fields of route select B
	localparam int POS_SHARED_DH_SOURCE_SEL   = 6;
	localparam int POS_SHARED_BG_SOURCE_SEL   = 5;
	localparam int POS_PORTH_HIGH_NIBBLE_ROUTE = 4;
	localparam int POS_PORTH_LOW_NIBBLE_ROUTE = 3;
	localparam int POS_PORTG_HIGH_NIBBLE_ROUTE = 2;
	localparam int POS_PORTG_LOW_NIBBLE_ROUTE = 1;
	localparam int POS_PORTF_HIGH_NIBBLE_ROUTE = 0;

	// Port slots in the pending register and pin vector
	localparam int PORT_B                     = 0;
	localparam int PORT_D                     = 1;
	localparam int PORT_E                     = 2;
	localparam int PORT_F                     = 3;
	localparam int PORT_G                     = 4;
	localparam int PORT_H                     = 5;
	localparam int NUM_PORTS                  = 6;

	// Sensitivity codes
	localparam logic [1:0] SENS_FALL_LOW      = 2'h0;
	localparam logic [1:0] SENS_RISE          = 2'h1;
	localparam logic [1:0] SENS_FALL          = 2'h2;
	localparam logic [1:0] SENS_BOTH          = 2'h3;

endpackage : exti_route_pkg

`default_nettype wire

// ### tb/exti_route_test.sv
// Self-checking bench for the external-interrupt port routing block.
// Assumes the one-wait-state Avalon-MM slave and a few-cycle pin filter.
`default_nettype none

module exti_route_test;
	timeunit 1ns;
	timeprecision 1ns;
	import exti_route_pkg::*;

	typedef struct {
		logic [7:0]  a;
		logic [7:0]  b;
		int          p;
		logic [7:0]  pin;
		logic [13:0] exp;
	} row_t;

	logic        clock;
	logic        reset;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic        mask_hi;
	logic        mask_lo;
	logic [7:0]  pins [6];
	wire logic [31:0] rdata;
	wire logic        waitreq;
	wire logic [3:0]  lines_lo;
	wire logic [3:0]  lines_hi;
	wire logic [5:0]  irqs;
	int          miscompares;
	int          checks_done;
	logic [7:0]  q;
	logic [3:0]  ridx [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'ha, 4'hb, 4'h6, 4'h7};

	// Expected value packs the port lines above the per-bit lines
	row_t rows [19] = '{
		'{8'h00, 8'h00, PORT_B, 8'h01, 14'h0001},
		'{8'h00, 8'h00, PORT_H, 8'h80, 14'h0080},
		'{8'h00, 8'h00, PORT_G, 8'h08, 14'h0008},
		'{8'h01, 8'h00, PORT_B, 8'h01, 14'h0100},
		'{8'h01, 8'h20, PORT_B, 8'h01, 14'h0000},
		'{8'h02, 8'h00, PORT_B, 8'h10, 14'h0100},
		'{8'h04, 8'h00, PORT_D, 8'h02, 14'h0200},
		'{8'h08, 8'h00, PORT_D, 8'h80, 14'h0200},
		'{8'h08, 8'h40, PORT_D, 8'h80, 14'h0000},
		'{8'h10, 8'h00, PORT_E, 8'h04, 14'h0400},
		'{8'h20, 8'h00, PORT_E, 8'h40, 14'h0400},
		'{8'h90, 8'h00, PORT_E, 8'h01, 14'h0000},
		'{8'hc0, 8'h00, PORT_F, 8'h08, 14'h0800},
		'{8'h80, 8'h01, PORT_F, 8'h20, 14'h0800},
		'{8'h00, 8'h22, PORT_G, 8'h01, 14'h1000},
		'{8'h00, 8'h24, PORT_G, 8'h10, 14'h1000},
		'{8'h00, 8'h48, PORT_H, 8'h02, 14'h2000},
		'{8'h00, 8'h50, PORT_H, 8'h80, 14'h2000},
		'{8'h00, 8'h08, PORT_H, 8'h02, 14'h0000}
	};

	exti_route DUT (
		.i_clock               (clock),
		.i_reset               (reset),
		.i_avs_address         (address),
		.i_avs_read            (read),
		.i_avs_write           (write),
		.i_avs_writedata       (wdata),
		.i_avs_byteenable      (be),
		.o_avs_readdata        (rdata),
		.o_avs_waitrequest     (waitreq),
		.i_cpu_mask_high       (mask_hi),
		.i_cpu_mask_low        (mask_lo),
		.i_portb_pins          (pins[0]),
		.i_portd_pins          (pins[1]),
		.i_porte_pins          (pins[2]),
		.i_portf_pins          (pins[3]),
		.i_portg_pins          (pins[4]),
		.i_porth_pins          (pins[5]),
		.o_per_bit_lines_low   (lines_lo),
		.o_per_bit_lines_high  (lines_hi),
		.o_portb_dedicated_irq (irqs[0]),
		.o_portd_dedicated_irq (irqs[1]),
		.o_porte_dedicated_irq (irqs[2]),
		.o_portf_dedicated_irq (irqs[3]),
		.o_portg_dedicated_irq (irqs[4]),
		.o_porth_dedicated_irq (irqs[5])
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic close_out();
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_reg

	task automatic check_out(input logic [13:0] exp);
		checks_done++;
		if ({irqs, lines_hi, lines_lo} !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time,
				{irqs, lines_hi, lines_lo}, exp);
		end
	endtask : check_out

	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic be0, output logic [7:0] rq);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		wdata <= {24'h0, d};
		be <= {3'h0, be0};
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (waitreq !== 1'b0) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, waitreq, 1'b0);
		end
		rq = rdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic be0 = 1'b1);
		logic [7:0] dummy;
		bus(1'b1, a, d, be0, dummy);
	endtask : wr

	task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] got;
		bus(1'b0, a, 8'h00, 1'b1, got);
		check_reg(got, exp);
	endtask : rd_check

	task automatic settle();
		repeat (10) @(posedge clock);
	endtask : settle

	task automatic clear_flags();
		wr(IDX_BIT_PENDING, 8'hff);
		wr(IDX_PORT_PENDING, 8'h3f);
	endtask : clear_flags

	task automatic set_pin(input int p, input logic [7:0] v);
		@(posedge clock);
		pins[p] <= v;
	endtask : set_pin

	task automatic do_reset();
		@(posedge clock);
		reset <= 1'b1;
		repeat (4) @(posedge clock);
		check_out(14'h0000);
		reset <= 1'b0;
	endtask : do_reset

	initial begin
		#3000000;
		miscompares++;
		close_out();
	end

	initial begin
		miscompares = 0;
		checks_done = 0;
		reset = 1'b1;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		wdata = 32'h0;
		be = 4'h0;
		mask_hi = 1'b0;
		mask_lo = 1'b0;
		for (int i = 0; i < 6; i++)
			pins[i] = 8'h00;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		foreach (ridx[i])
			rd_check(ridx[i], 8'h00);
		// Sensitivity stays locked with only one of the two mask bits set
		for (int m = 1; m < 3; m++) begin
			@(posedge clock);
			mask_hi <= m[0];
			mask_lo <= m[1];
			wr(IDX_BIT0_3_SENS, 8'hff);
			rd_check(IDX_BIT0_3_SENS, 8'h00);
		end
		@(posedge clock);
		mask_hi <= 1'b1;
		mask_lo <= 1'b1;
		wr(IDX_BIT0_3_SENS, 8'h55);
		wr(IDX_BIT4_7_SENS, 8'h55);
		wr(IDX_PORT_SENS, 8'h55);
		wr(IDX_PORT_GH_SENS, 8'h05);
		rd_check(IDX_BIT0_3_SENS, 8'h55);
		clear_flags();
		foreach (rows[i]) begin
			wr(IDX_ROUTE_SEL_A, rows[i].a);
			wr(IDX_ROUTE_SEL_B, rows[i].b);
			set_pin(rows[i].p, rows[i].pin);
			settle();
			check_out(rows[i].exp);
			set_pin(rows[i].p, 8'h00);
			settle();
			clear_flags();
		end
		// Every sensitivity code on the port B line
		wr(IDX_ROUTE_SEL_A, 8'h01);
		wr(IDX_ROUTE_SEL_B, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_PORT_SENS, {6'h15, c[1:0]});
			clear_flags();
			set_pin(PORT_B, 8'h01);
			settle();
			check_out({5'h00, c != 2, 8'h00});
			clear_flags();
			set_pin(PORT_B, 8'h00);
			settle();
			check_out({5'h00, c != 1, 8'h00});
			clear_flags();
			settle();
			check_out({5'h00, c == 0, 8'h00});
		end
		wr(IDX_PORT_SENS, 8'h55);
		clear_flags();
		// Writing zero keeps a flag, writing one clears it
		wr(IDX_ROUTE_SEL_A, 8'h00);
		set_pin(PORT_B, 8'h01);
		settle();
		wr(IDX_BIT_PENDING, 8'h00);
		rd_check(IDX_BIT_PENDING, 8'h01);
		wr(IDX_BIT_PENDING, 8'h01);
		rd_check(IDX_BIT_PENDING, 8'h00);
		wr(IDX_ROUTE_SEL_A, 8'hff, 1'b0);
		rd_check(IDX_ROUTE_SEL_A, 8'h00);
		wr(4'h7, 8'hff);
		rd_check(4'h7, 8'h00);
		wr(IDX_ROUTE_SEL_B, 8'hff);
		rd_check(IDX_ROUTE_SEL_B, 8'h7f);
		wr(IDX_ROUTE_SEL_A, 8'hff);
		rd_check(IDX_ROUTE_SEL_A, 8'hff);
		do_reset();
		rd_check(IDX_ROUTE_SEL_A, 8'h00);
		rd_check(IDX_ROUTE_SEL_B, 8'h00);
		close_out();
	end

endmodule : exti_route_test

`default_nettype wire
